// [src/alarm_trip_ctrl.sv]
/*
 * alarm trip controller: threshold checks, trip latch, clearing modes,
 * snooze, settings validation and a small register port.
 * assumes button inputs are already debounced and classified into press
 * lengths as synchronous one-cycle pulses on clk; measurements are words
 * on clk updated by the measurement path.
 */
`timescale 1ns/1ns
module alarm_trip_ctrl #(
    parameter int MW        = 16,
    parameter int TICK_DIV  = alarm_pkg::TICK_CYCLES
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            alarm_menu_active,
    input  wire logic            menu_key_one,
    input  wire logic            clear_medium_push,
    input  wire logic            snooze_long_push,
    input  wire logic            relay_short_push,
    input  wire logic [MW-1:0]   meas_value,
    input  wire logic [MW-1:0]   fwd_power,
    input  wire logic [MW-1:0]   swr_value,
    input  wire logic [3:0]      addr,
    input  wire logic [31:0]     wdata,
    input  wire logic            wr,
    input  wire logic            rd,
    output logic [31:0]          rdata,
    output logic                 trip_led,
    output logic                 sounder,
    output logic                 relay,
    output logic                 snooze_led,
    output logic                 warn_led,
    output logic                 prot_led,
    output logic                 threshold_order_error,
    output logic                 no_threshold_error
);
    import alarm_pkg::*;

    // register indices (word address)
    localparam logic [3:0] A_CTRL  = 4'h0;
    localparam logic [3:0] A_TIME  = 4'h1;
    localparam logic [3:0] A_PWR   = 4'h2;
    localparam logic [3:0] A_SWR   = 4'h3;
    localparam logic [3:0] A_STAT  = 4'h4;

    // settings
    logic              prot_en, next_prot_en;
    clear_mode_e       cmode, next_cmode;
    trip_out_e         tout, next_tout;
    coupler_e          ctype, next_ctype;
    logic [MS_W-1:0]   trip_ms, next_trip_ms;
    logic [MS_W-1:0]   reset_ms, next_reset_ms;
    logic [SNOOZE_S_W-1:0] snooze_s, next_snooze_s;
    logic [MW-1:0]     low_th, next_low_th, high_th, next_high_th;
    logic              low_ign, next_low_ign, high_ign, next_high_ign;
    logic [MW-1:0]     swr_trip, next_swr_trip, swr_warn, next_swr_warn;
    logic              swr_ign, next_swr_ign, warn_ign, next_warn_ign;
    logic [MW-1:0]     min_valid, next_min_valid;
    logic              order_err, next_order_err, none_err, next_none_err;

    // settings: writes checked before acceptance except reset_ms and prot_en, menu key toggle
    always_comb begin
        next_prot_en   = prot_en;
        next_cmode     = cmode;
        next_tout      = tout;
        next_ctype     = ctype;
        next_trip_ms   = trip_ms;
        next_reset_ms  = reset_ms;
        next_snooze_s  = snooze_s;
        next_low_th    = low_th;
        next_high_th   = high_th;
        next_low_ign   = low_ign;
        next_high_ign  = high_ign;
        next_swr_trip  = swr_trip;
        next_swr_warn  = swr_warn;
        next_swr_ign   = swr_ign;
        next_warn_ign  = warn_ign;
        next_min_valid = min_valid;
        next_order_err = order_err;
        next_none_err  = none_err;
        if (alarm_menu_active && menu_key_one) begin
            next_prot_en = !prot_en;
        end
        if (wr) begin
            case (addr)
                A_CTRL: begin
                    next_prot_en = wdata[0];
                    if (wdata[2:1] != 2'h3) begin
                        next_cmode = clear_mode_e'(wdata[2:1]);
                    end
                    if (wdata[4:3] != 2'h3) begin
                        next_tout = trip_out_e'(wdata[4:3]);
                    end
                    if (wdata[6:5] != 2'h3) begin
                        next_ctype = coupler_e'(wdata[6:5]);
                    end
                end
                A_TIME: begin
                    if (wdata[15:0] >= 16'(INTERVAL_MIN_MS)
                            && 17'(wdata[15:0]) <= 17'(INTERVAL_MAX_MS)) begin
                        next_trip_ms = 17'(wdata[15:0]);
                    end
                    next_reset_ms = 17'(wdata[31:16]);
                end
                A_PWR: begin
                    // bits 31/30 flag ignore; 29:15 high, 14:0 low
                    if (!wdata[31] && !wdata[30]
                            && wdata[29:15] <= wdata[14:0]) begin
                        next_order_err = 1'b1;
                    end else if (wdata[31] && wdata[30] && swr_ign) begin
                        next_none_err = 1'b1;
                    end else begin
                        next_low_ign  = wdata[30];
                        next_high_ign = wdata[31];
                        next_low_th   = MW'(wdata[14:0]);
                        next_high_th  = MW'(wdata[29:15]);
                        next_order_err = 1'b0;
                        next_none_err  = 1'b0;
                    end
                end
                A_SWR: begin
                    // 31 swr ignore, 30 warn ignore, 29:23 snooze s
                    if (wdata[31] && low_ign && high_ign) begin
                        next_none_err = 1'b1;
                    end else begin
                        next_swr_ign  = wdata[31];
                        next_warn_ign = wdata[30];
                        next_swr_trip = MW'(wdata[7:0]);
                        next_swr_warn = MW'(wdata[15:8]);
                        next_min_valid = MW'(wdata[22:16]);
                        if (wdata[29:23] >= 7'h05 && wdata[29:23] <= 7'h63) begin
                            next_snooze_s = wdata[29:23];
                        end
                        next_none_err = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prot_en   <= PROT_EN_RST;
            cmode     <= CLR_MANUAL;
            tout      <= OUT_SOUNDER;
            ctype     <= CPL_POWER;
            trip_ms   <= TRIP_MS_RST;
            reset_ms  <= RESET_MS_RST;
            snooze_s  <= SNOOZE_S_RST;
            low_th    <= '0;
            high_th   <= '1;
            low_ign   <= 1'b1;
            high_ign  <= 1'b1;
            swr_trip  <= '0;
            swr_warn  <= '0;
            swr_ign   <= 1'b0;
            warn_ign  <= 1'b1;
            min_valid <= '0;
            order_err <= 1'b0;
            none_err  <= 1'b0;
        end else begin
            prot_en   <= next_prot_en;
            cmode     <= next_cmode;
            tout      <= next_tout;
            ctype     <= next_ctype;
            trip_ms   <= next_trip_ms;
            reset_ms  <= next_reset_ms;
            snooze_s  <= next_snooze_s;
            low_th    <= next_low_th;
            high_th   <= next_high_th;
            low_ign   <= next_low_ign;
            high_ign  <= next_high_ign;
            swr_trip  <= next_swr_trip;
            swr_warn  <= next_swr_warn;
            swr_ign   <= next_swr_ign;
            warn_ign  <= next_warn_ign;
            min_valid <= next_min_valid;
            order_err <= next_order_err;
            none_err  <= next_none_err;
        end
    end

    // fault detection
    logic          is_power;
    logic [MW-1:0] mon;
    logic          swr_valid, swr_fault, pwr_fault, any_fault;
    assign is_power  = (ctype == CPL_POWER);
    assign mon       = is_power ? fwd_power : meas_value;
    assign swr_valid = is_power && fwd_power >= min_valid;
    assign swr_fault = swr_valid && !swr_ign && swr_value > swr_trip;
    assign pwr_fault = (!low_ign && mon < low_th)
                       || (!high_ign && mon > high_th);
    assign any_fault = swr_fault || pwr_fault;

    // millisecond tick
    logic [$clog2(TICK_DIV)-1:0] div, next_div;
    logic                        tick;
    assign tick     = (div == TICK_DIV[$clog2(TICK_DIV)-1:0] - 1'b1);
    assign next_div = tick ? '0 : div + 1'b1;

    // trip state machine
    alarm_state_e state, next_state;
    timer_if #(.W(MS_W)) ptif (); // power persistence
    timer_if #(.W(MS_W)) stif (); // reset / snooze interval
    logic snooze_enter;
    assign snooze_enter = snooze_long_push && prot_en;

    always_comb begin
        next_state = state;
        stif.start = 1'b0;
        case (state)
            ST_ARMED: begin
                if (snooze_enter) begin
                    next_state = ST_SNOOZE;
                    stif.start = 1'b1;
                end else if (prot_en && (swr_fault || (pwr_fault && ptif.done))) begin
                    next_state = ST_TRIPPED;
                    stif.start = 1'b1;
                end
            end
            ST_TRIPPED: begin
                if (!prot_en || clear_medium_push) begin
                    next_state = ST_ARMED;
                end else if (snooze_enter) begin
                    next_state = ST_SNOOZE;
                    stif.start = 1'b1;
                end else if (cmode == CLR_AUTO && stif.done) begin
                    next_state = ST_ARMED;
                end else if (cmode == CLR_CONDITIONAL_AUTO_CLEAR_MODE && stif.done && !any_fault) begin
                    next_state = ST_ARMED;
                end
                // manual mode: only the clear push, snooze entry or protection off leaves
            end
            ST_SNOOZE: begin
                if (relay_short_push) begin
                    stif.start = 1'b1;
                end else if (stif.done) begin
                    next_state = ST_ARMED;
                end
            end
            default: next_state = ST_ARMED;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_ARMED;
            div   <= '0;
        end else begin
            state <= next_state;
            div   <= next_div;
        end
    end

    // timers: persistence restarts whenever the power fault lapses
    assign ptif.tick  = tick;
    assign ptif.start = !pwr_fault || state != ST_ARMED;
    assign ptif.limit = trip_ms;
    assign stif.tick  = tick;
    assign stif.limit = (state == ST_SNOOZE || snooze_enter)
                        ? MS_W'(MS_W'(snooze_s) * MS_W'(MS_PER_S)) : reset_ms;

    interval_timer #(.W(MS_W)) persist_timer (
        .clk (clk),
        .rst (rst),
        .tif (ptif)
    );
    interval_timer #(.W(MS_W)) clear_timer (
        .clk (clk),
        .rst (rst),
        .tif (stif)
    );

    // outputs
    logic tripped;
    assign tripped    = (state == ST_TRIPPED);
    assign trip_led   = tripped;
    assign sounder    = tripped && prot_en && tout != OUT_RELAY;
    assign relay      = tripped && prot_en && tout != OUT_SOUNDER;
    assign snooze_led = (state == ST_SNOOZE);
    assign warn_led   = is_power && swr_valid && !warn_ign
                        && swr_value > swr_warn;
    assign prot_led   = prot_en;
    assign threshold_order_error = order_err;
    assign no_threshold_error    = none_err;

    // read port, data one cycle after strobe
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        if (rd) begin
            case (addr)
                A_CTRL: next_rdata = {25'h0, ctype, tout, cmode, prot_en};
                A_TIME: next_rdata = {15'(reset_ms), 17'(trip_ms)};
                A_STAT: next_rdata = {24'h0, state, warn_led, any_fault,
                                      tripped, none_err, order_err};
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // checks
    snooze_clears_a: assert property (@(posedge clk) disable iff (rst)
        (snooze_enter && state == ST_TRIPPED && !clear_medium_push) |=> !trip_led && snooze_led)
        else $error("snooze entry did not clear trip");
    clear_push_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_TRIPPED && clear_medium_push) |=> !trip_led)
        else $error("clear push did not clear trip");
    disabled_quiet_a: assert property (@(posedge clk) disable iff (rst)
        !prot_en |=> !sounder && !relay)
        else $error("outputs active while disabled");
    snooze_led_a: assert property (@(posedge clk) disable iff (rst)
        snooze_led == (state == ST_SNOOZE))
        else $error("snooze lamp mismatch");
    menu_toggle_a: assert property (@(posedge clk) disable iff (rst)
        (alarm_menu_active && menu_key_one && !wr) |=> prot_en != $past(prot_en))
        else $error("menu key did not toggle");
    order_reject_a: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == A_PWR && !wdata[31] && !wdata[30] && wdata[29:15] <= wdata[14:0])
        |=> threshold_order_error && $stable(low_th) && $stable(high_th))
        else $error("bad threshold order accepted");
    manual_hold_a: assert property (@(posedge clk) disable iff (rst)
        (tripped && cmode == CLR_MANUAL && prot_en && !clear_medium_push
         && !snooze_enter) |=> tripped)
        else $error("manual trip cleared itself");
    generic_swr_a: assert property (@(posedge clk) disable iff (rst)
        !is_power |-> !warn_led && !swr_fault)
        else $error("swr active for generic coupler");
    trip_cov: cover property (@(posedge clk) disable iff (rst) tripped && sounder);
    snooze_cov: cover property (@(posedge clk) disable iff (rst)
        snooze_led && relay_short_push);
    auto_cov: cover property (@(posedge clk) disable iff (rst)
        tripped && cmode == CLR_AUTO ##1 !tripped);
endmodule

// [src/alarm_pkg.sv]
/*
 * constants and types shared by the alarm trip controller and its helpers.
 * assumes a 50 MHz system clock and measurement words already scaled alike.
 */
// Overview of operation
// - menu key one toggles protection enable
// - trip lights indicator, drives sounder/relay per selection
// - medium clear push clears trip always
// - auto mode clears trip after interval
// - persisting fault retrips endlessly after auto clear
// - manual clear works at once in auto
// - conditional mode clears after interval without faults
// - long snooze push masks faults for duration
// - short relay push restarts running snooze timer
// - entering snooze clears active trip
// - snooze lamp lit exactly while snoozing
// - reject thresholds when high not above low
// - reject settings with all thresholds ignored
// - ammeter/generic types disable swr comparisons
// - fault when outside enabled low/high bounds
// - ammeter/generic with no power bounds never trips
// - power fault trips after trip interval persistence
// - manual mode holds trip until clear push, snooze entry or protection off
// - swr warning lamp only, no trip effect
// - low forward power excluded from swr fault
package alarm_pkg;
    localparam int CLK_HZ         = 50_000_000;
    localparam int TICK_US        = 1000;
    localparam int TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
    localparam int MS_W           = 17;
    localparam int SNOOZE_S_W     = 7;
    localparam int MS_PER_S       = 1000;
    localparam int INTERVAL_MIN_MS = 50;
    localparam int INTERVAL_MAX_MS = 30_000;
    localparam logic [MS_W-1:0] TRIP_MS_RST   = 17'h007D0;
    localparam logic [MS_W-1:0] RESET_MS_RST  = 17'h00BB8;
    localparam logic [SNOOZE_S_W-1:0] SNOOZE_S_RST = 7'h14;
    localparam logic PROT_EN_RST  = 1'b1;

    typedef enum logic [1:0] {
        CLR_MANUAL = 2'h0,
        CLR_AUTO   = 2'h1,
        CLR_CONDITIONAL_AUTO_CLEAR_MODE   = 2'h2
    } clear_mode_e;

    typedef enum logic [1:0] {
        OUT_SOUNDER = 2'h0,
        OUT_RELAY   = 2'h1,
        OUT_BOTH    = 2'h2
    } trip_out_e;

    typedef enum logic [1:0] {
        CPL_POWER   = 2'h0,
        CPL_AMMETER = 2'h1,
        CPL_GENERIC = 2'h2
    } coupler_e;

    typedef enum logic [2:0] {
        ST_ARMED   = 3'b001,
        ST_TRIPPED = 3'b010,
        ST_SNOOZE  = 3'b100
    } alarm_state_e;
endpackage

// [src/timer_if.sv]
/*
 * bundle joining the main controller to its millisecond interval timer.
 * assumes a single clock domain.
 */
`timescale 1ns/1ns
interface timer_if #(parameter int W = 17);
    logic         start;
    logic         tick;
    logic [W-1:0] limit;
    logic         done;
    modport owner (output start, output tick, output limit, input done);
    modport timer (input start, input tick, input limit, output done);
endinterface

// [src/interval_timer.sv]
/*
 * millisecond interval timer: restart loads zero, done holds once limit ms pass.
 * assumes tick is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ns
module interval_timer #(
    parameter int W = 17
) (
    input  wire logic clk,
    input  wire logic rst,
    timer_if.timer    tif
);
    import alarm_pkg::*;

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    // count ticks up to the limit, restart wins
    always_comb begin
        next_count = count;
        if (tif.start) begin
            next_count = '0;
        end else if (tif.tick && count < tif.limit) begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign tif.done = !tif.start && count >= tif.limit;
endmodule

// [test/panel_model.sv]
/*
 * front panel model: alarm menu level and one-cycle button pulses.
 * assumes the controller samples every pulse on the rising edge of clk.
 */
`timescale 1ns/1ns
module panel_model (
    input  wire logic clk,
    output logic      menu_active,
    output logic      key_one,
    output logic      clear_push,
    output logic      snooze_push,
    output logic      relay_push
);
    logic [3:0] btn; // one bit per button
    assign {key_one, relay_push, snooze_push, clear_push} = btn;

    // buttons idle at time zero
    initial begin
        menu_active = 1'b0;
        btn = 4'h0;
    end

    // one pulse: 0 clear, 1 snooze, 2 relay, 3 menu key
    task automatic push(input int k);
        @(posedge clk);
        btn <= 4'h1 << k;
        @(posedge clk);
        btn <= 4'h0;
    endtask

    // alarm menu shown or hidden
    task automatic menu(input logic v);
        @(posedge clk);
        menu_active <= v;
    endtask
endmodule

// [test/testbench.sv]
/*
 * self-checking bench for the alarm trip controller.
 * assumes alarm_pkg, timer_if, interval_timer and panel_model come first.
 */
`timescale 1ns/1ns
module testbench;
    import alarm_pkg::*;
    localparam logic [31:0] SWR_W = 32'h0290_2030;
    localparam logic [31:0] PWR_W = 32'h01F4_0005;
    localparam logic [15:0] OK_V  = 16'h01F4;
    logic        clk, rst, wr, rd;
    logic [15:0] meas_value, fwd_power, swr_value;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, rv;
    logic        menu_act, key_one, clr_p, snz_p, rly_p;
    logic        trip_led, sounder, relay, snooze_led, warn_led, prot_led;
    logic        ord_err, none_err;
    logic [2:0]  outs;
    int          mismatches, n_compared, n;

    // trip, sounder and relay seen together
    assign outs = {trip_led, sounder, relay};

    // front panel buttons
    panel_model i_panel (
        .clk         (clk),
        .menu_active (menu_act),
        .key_one     (key_one),
        .clear_push  (clr_p),
        .snooze_push (snz_p),
        .relay_push  (rly_p)
    );

    // block under test, 10 cycles to the millisecond
    alarm_trip_ctrl #(.MW(16), .TICK_DIV(10)) i_dut (
        .clk                   (clk),
        .rst                   (rst),
        .alarm_menu_active     (menu_act),
        .menu_key_one          (key_one),
        .clear_medium_push     (clr_p),
        .snooze_long_push      (snz_p),
        .relay_short_push      (rly_p),
        .meas_value            (meas_value),
        .fwd_power             (fwd_power),
        .swr_value             (swr_value),
        .addr                  (addr),
        .wdata                 (wdata),
        .wr                    (wr),
        .rd                    (rd),
        .rdata                 (rdata),
        .trip_led              (trip_led),
        .sounder               (sounder),
        .relay                 (relay),
        .snooze_led            (snooze_led),
        .warn_led              (warn_led),
        .prot_led              (prot_led),
        .threshold_order_error (ord_err),
        .no_threshold_error    (none_err)
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic test_done;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_span(input string nm, input int lo, input int hi, input int g);
        n_compared++;
        if (g < lo || g > hi) begin
            mismatches++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // count cycles until the trip lamp reaches a level
    task automatic wait_trip(input logic lvl, input int max);
        n = 0;
        while (trip_led !== lvl && n < max) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic setm(input logic [15:0] f, input logic [15:0] s, input logic [15:0] m);
        @(posedge clk);
        fwd_power  <= f;
        swr_value  <= s;
        meas_value <= m;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        rv = rdata;
    endtask

    function automatic logic [31:0] ctrl_w(input logic [1:0] m, input logic [1:0] o,
                                           input logic [1:0] c);
        return {25'h0, c, o, m, 1'b1};
    endfunction

    task automatic t_power;
        wr_reg(4'h0, ctrl_w(CLR_MANUAL, OUT_BOTH, CPL_POWER));
        setm(16'h0002, 16'h0010, OK_V);
        cyc(300);
        setm(OK_V, 16'h0010, OK_V);
        setm(16'h0002, 16'h0010, OK_V);
        cyc(300);
        chk_word("trip after gap", 0, trip_led);
        wait_trip(1'b1, 400);
        chk_span("trip delay", 170, 240, n);
        chk_word("trip outputs", 3'h7, outs);
        rd_reg(4'h4);
        chk_word("status", 32'h4C, rv & 32'hEC);
        setm(OK_V, 16'h0010, OK_V);
        cyc(800);
        chk_word("manual hold", 1, trip_led);
        i_panel.push(0);
        cyc(1);
        chk_word("manual clear", 3'h0, outs);
    endtask

    // sounder only, then relay only
    task automatic t_outsel;
        for (int i = 0; i < 2; i++) begin
            wr_reg(4'h0, ctrl_w(CLR_MANUAL, i[1:0], CPL_POWER));
            setm(OK_V, 16'h0040, OK_V);
            cyc(3);
            chk_word("selected outputs", (i == 0) ? 3'h6 : 3'h5, outs);
            setm(OK_V, 16'h0010, OK_V);
            i_panel.push(0);
        end
        wr_reg(4'h0, ctrl_w(CLR_MANUAL, OUT_BOTH, CPL_POWER));
        setm(OK_V, 16'h0028, OK_V);
        cyc(3);
        chk_word("warning lamp", 2'h1, {trip_led, warn_led});
        setm(16'h0008, 16'h0040, 16'h0008);
        cyc(5);
        chk_word("low power swr", 0, trip_led);
        setm(OK_V, 16'h0010, OK_V);
        cyc(2);
        chk_word("warning off", 0, warn_led);
    endtask

    task automatic t_auto;
        wr_reg(4'h0, ctrl_w(CLR_AUTO, OUT_BOTH, CPL_POWER));
        setm(16'h0002, 16'h0010, OK_V);
        wait_trip(1'b1, 700);
        chk_span("auto trip", 470, 540, n);
        wait_trip(1'b0, 700);
        chk_span("auto clear", 470, 540, n);
        wait_trip(1'b1, 700);
        chk_span("auto retrip", 470, 540, n);
        i_panel.push(0);
        cyc(1);
        chk_word("auto manual clear", 0, trip_led);
        setm(OK_V, 16'h0010, OK_V);
    endtask

    task automatic t_conditional_auto_clear_mode;
        wr_reg(4'h0, ctrl_w(CLR_CONDITIONAL_AUTO_CLEAR_MODE, OUT_BOTH, CPL_POWER));
        setm(16'h0002, 16'h0010, OK_V);
        wait_trip(1'b1, 700);
        cyc(700);
        chk_word("conditional_auto_clear_mode hold", 1, trip_led);
        setm(OK_V, 16'h0010, OK_V);
        wait_trip(1'b0, 30);
        chk_span("conditional_auto_clear_mode clear", 0, 20, n);
    endtask

    task automatic t_errors;
        wr_reg(4'h2, 32'h0064_00C8);
        cyc(2);
        chk_word("order error", 1, ord_err);
        setm(16'h0096, 16'h0010, OK_V);
        cyc(600);
        chk_word("old bounds kept", 0, trip_led);
        wr_reg(4'h2, PWR_W);
        cyc(2);
        chk_word("order error off", 0, ord_err);
        wr_reg(4'h3, SWR_W | 32'h8000_0000);
        wr_reg(4'h2, PWR_W | 32'hC000_0000);
        cyc(2);
        chk_word("none error", 1, none_err);
        rd_reg(4'h4);
        chk_word("status errors", 2'h2, rv[1:0]);
        setm(16'h0002, 16'h0010, OK_V);
        wait_trip(1'b1, 700);
        chk_word("bounds retained", 1, trip_led);
        setm(OK_V, 16'h0010, OK_V);
        i_panel.push(0);
        wr_reg(4'h2, PWR_W);
        wr_reg(4'h3, SWR_W);
    endtask

    task automatic t_meter;
        wr_reg(4'h0, ctrl_w(CLR_MANUAL, OUT_BOTH, CPL_AMMETER));
        setm(OK_V, 16'h0040, OK_V);
        cyc(600);
        chk_word("no swr compare", 2'h0, {trip_led, warn_led});
        setm(OK_V, 16'h0040, 16'h07D0);
        wait_trip(1'b1, 700);
        chk_span("high bound trip", 470, 540, n);
        setm(OK_V, 16'h0040, 16'h0002);
        i_panel.push(0);
        wr_reg(4'h0, ctrl_w(CLR_MANUAL, OUT_BOTH, CPL_GENERIC));
        wr_reg(4'h2, PWR_W | 32'hC000_0000);
        cyc(700);
        chk_word("never trips", 2'h0, {trip_led, none_err});
        setm(OK_V, 16'h0010, OK_V);
        wr_reg(4'h2, PWR_W);
        wr_reg(4'h0, ctrl_w(CLR_MANUAL, OUT_BOTH, CPL_POWER));
    endtask

    task automatic t_snooze;
        setm(OK_V, 16'h0040, OK_V);
        cyc(3);
        chk_word("swr trip", 1, trip_led);
        i_panel.push(1);
        cyc(1);
        chk_word("snooze entry", 2'h1, {trip_led, snooze_led});
        cyc(1000);
        i_panel.push(2);
        cyc(49600);
        chk_word("snooze restarted", 2'h1, {trip_led, snooze_led});
        cyc(800);
        chk_word("snooze over", 2'h2, {trip_led, snooze_led});
        setm(OK_V, 16'h0010, OK_V);
        i_panel.push(0);
    endtask

    task automatic t_menu;
        setm(OK_V, 16'h0040, OK_V);
        i_panel.menu(1'b1);
        i_panel.push(3);
        cyc(3);
        chk_word("protection off", 4'h0, {prot_led, outs});
        i_panel.menu(1'b0);
        i_panel.push(3);
        cyc(1);
        chk_word("menu inactive", 0, prot_led);
        i_panel.menu(1'b1);
        i_panel.push(3);
        cyc(3);
        chk_word("protection on", 4'hF, {prot_led, outs});
        i_panel.menu(1'b0);
        setm(OK_V, 16'h0010, OK_V);
        i_panel.push(0);
    endtask

    // watchdog well beyond the expected run
    initial begin
        #1_600_000;
        mismatches++;
        test_done();
    end

    // reset, configure, then every scenario in turn
    initial begin
        {rst, wr, rd, addr, wdata} = {1'b1, 1'b0, 1'b0, 4'h0, 32'h0};
        {fwd_power, swr_value, meas_value} = {OK_V, 16'h0000, OK_V};
        mismatches = 0;
        n_compared = 0;
        cyc(5);
        chk_word("reset outputs", 8'h04, {outs, snooze_led, warn_led, prot_led,
                 ord_err, none_err});
        @(posedge clk);
        rst <= 1'b0;
        wr_reg(4'h3, SWR_W);
        wr_reg(4'h2, PWR_W);
        wr_reg(4'h1, 32'h0032_0032);
        setm(OK_V, 16'h0010, OK_V);
        rd_reg(4'hF);
        chk_word("unmapped read", 32'h0, rv);
        t_power();
        t_outsel();
        t_auto();
        t_conditional_auto_clear_mode();
        t_errors();
        t_meter();
        t_snooze();
        t_menu();
        test_done();
    end
endmodule
